//--- sim/opas_regs_sva.sv
// opas_regs_sva: port assertions for the operand pointer and alu status block
// assumes a bind into opas_regs; status views trail their cause by two edges
`timescale 1ns/1ps
`default_nettype none
module opas_regs_sva (
    input wire logic        ref_clk_in,
    input wire logic        reset_n_in,
    input wire logic [7:0]  first_source_select_in,
    input wire logic [7:0]  first_reg_num_out,
    input wire logic        spr_wr_in,
    input wire logic [7:0]  spr_addr_in,
    input wire logic [31:0] spr_wdata_in,
    input wire logic [31:0] spr_rdata_out,
    input wire logic [2:0]  alu_op_in,
    input wire logic [32:0] alu_result_in,
    input wire logic        alu_msb_carry_in,
    input wire logic        div_flag_force_one_in,
    input wire logic        alu_carry_in_out,
    input wire logic        alu_subtract_out,
    input wire logic        endianness_select_in,
    input wire logic [1:0]  byte_lane_out,
    input wire logic        half_word_upper_out,
    input wire logic [4:0]  funnel_shift_amount_out,
    input wire logic [31:0] alu_status_out
);
    logic st_wr;  // a status write overrides the alu outcome of that cycle
    assign st_wr = spr_wr_in && spr_addr_in == opas_pkg::REG_ALU_STAT;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // flag properties keep the cause in local variables
    property nz_p;
        logic [32:0] r;
        (alu_op_in == opas_pkg::OPAS_OP_LOGIC && !st_wr, r = alu_result_in)
            |-> ##2 alu_status_out[9:8] == {r[31], r[31:0] == 32'h0};
    endproperty
    property ar_p;
        logic [32:0] r;
        logic        m;
        (alu_op_in == opas_pkg::OPAS_OP_ARITH && !st_wr, r = alu_result_in, m = alu_msb_carry_in)
            |-> ##2 alu_status_out[10:7] == {r[32] ^ m, r[31], r[31:0] == 32'h0, r[32]};
    endproperty
    property de_p;
        logic f;
        (alu_op_in == opas_pkg::OPAS_OP_DIVEND && !st_wr,
         f = div_flag_force_one_in | !alu_result_in[32]) |-> ##2 alu_status_out[11] == f;
    endproperty
    property wr_p;
        logic [31:0] w;
        (st_wr, w = spr_wdata_in) |-> ##2 alu_status_out == {20'h0, w[11:0]};
    endproperty
    operand_bypass_a:
        assert property ($past(reset_n_in) && $past(first_source_select_in) != 8'h00
            |-> first_reg_num_out == $past(first_source_select_in)) else $error("bypass");
    logic_flags_a:
        assert property (nz_p) else $error("logic flags");
    arith_flags_a:
        assert property (ar_p) else $error("arith flags");
    div_end_a:
        assert property (de_p) else $error("divide flag");
    status_write_a:
        assert property (wr_p) else $error("status write");
    alias_read_a:
        assert property ($past(reset_n_in) && $past(spr_addr_in) == opas_pkg::REG_BYTE_IDX
            |-> spr_rdata_out == {30'h0, alu_status_out[6:5]}) else $error("alias read");
    flag_copies_a:
        assert property (alu_subtract_out == alu_status_out[11]
            && alu_carry_in_out == alu_status_out[7]) else $error("flag copies");
    field_views_a:
        assert property ($past(reset_n_in) |-> byte_lane_out == (alu_status_out[6:5]
            ^ {2{$past(endianness_select_in)}}) && half_word_upper_out == byte_lane_out[1]
            && funnel_shift_amount_out == alu_status_out[4:0]) else $error("views");
    cover property (st_wr);
    cover property (alu_op_in == opas_pkg::OPAS_OP_DIVEND);
    cover property ($past(spr_addr_in) == opas_pkg::REG_BYTE_IDX);
endmodule : opas_regs_sva
bind opas_regs opas_regs_sva u_sva (.*);
`default_nettype wire

//--- sim/operand_pointer_alu_status_bench.sv
// operand_pointer_alu_status_bench: self-checking bench for opas_regs
// assumes one-cycle answers; both byte lane source modes are driven at random
`timescale 1ns/1ps
`default_nettype none
module operand_pointer_alu_status_bench;
    logic        ref_clk_in = 1'b0, reset_n_in = 1'b0, spr_wr_in = 1'b0;
    logic        spr_wr_fsh_alias_in = 1'b0, ls_valid_in = 1'b0, alu_msb_carry_in = 1'b0;
    logic        load_store_sets_byte_index_in = 1'b0, endianness_select_in = 1'b0;
    logic        byte_lane_source_select_in = 1'b0, div_flag_force_one_in = 1'b0;
    logic        alu_carry_in_out, alu_subtract_out, half_word_upper_out;
    logic [1:0]  ls_addr_low_in = 2'h0, byte_lane_out;
    logic [2:0]  alu_op_in = 3'h0, op;
    logic [4:0]  funnel_shift_amount_out;
    logic [7:0]  first_source_select_in = 8'h01, second_source_select_in = 8'h01;
    logic [7:0]  spr_addr_in = 8'h00, first_reg_num_out, second_reg_num_out;
    logic [31:0] spr_wdata_in = 32'h0, spr_rdata_out, alu_status_out, d;
    logic [32:0] alu_result_in = 33'h0, r;
    logic [11:0] st = 12'h000;  // model of the live status bits
    int          n_mismatch = 0, checked = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    opas_regs dut (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // drop strobes, then compare every status view once it has landed
    task automatic settle;
        @(posedge ref_clk_in);
        {spr_wr_in, spr_wr_fsh_alias_in, ls_valid_in} <= 3'h0;
        alu_op_in <= opas_pkg::OPAS_OP_NONE;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk(alu_status_out, {20'h0, st});
        chk(byte_lane_out, st[6:5] ^ {2{endianness_select_in}});
        chk(half_word_upper_out, st[6] ^ endianness_select_in);
        chk(funnel_shift_amount_out, st[4:0]);
        chk({alu_subtract_out, alu_carry_in_out}, {st[11], st[7]});
    endtask : settle
    task automatic wr(input logic fa, input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_in);
        spr_wr_in <= !fa;
        spr_wr_fsh_alias_in <= fa;
        spr_addr_in <= a;
        spr_wdata_in <= v;
        settle();
    endtask : wr
    // rd and opnd sample one edge after the request edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_in);
        spr_addr_in <= a;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk(spr_rdata_out, exp);
    endtask : rd
    task automatic opnd(input logic [7:0] a, input logic [7:0] b, input logic [15:0] exp);
        @(posedge ref_clk_in);
        first_source_select_in <= a;
        second_source_select_in <= b;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk({first_reg_num_out, second_reg_num_out}, exp);
    endtask : opnd
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_mismatch++;
        close_out();
    end
    initial begin
        d = $urandom(50173);
        repeat (5) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            d = $urandom();
            wr(1'b0, opas_pkg::REG_PTR_A, d);
            rd(opas_pkg::REG_PTR_A, {22'h0, d[9:2], 2'h0});
            wr(1'b0, opas_pkg::REG_PTR_B, ~d);
            rd(opas_pkg::REG_PTR_B, {22'h0, ~d[9:2], 2'h0});
            opnd(8'h00, 8'h00, {d[9:2], ~d[9:2]});
            opnd(d[7:0] | 8'h01, 8'h00, {d[7:0] | 8'h01, ~d[9:2]});
            wr(1'b0, opas_pkg::REG_MULDIV_EXT, d ^ 32'h5a5a_0f0f);
            rd(opas_pkg::REG_MULDIV_EXT, d ^ 32'h5a5a_0f0f);
        end
        rd(8'h86, 32'h0);
        $display("pointer test done");
        for (int i = 0; i < 8; i++) begin
            d = $urandom();
            st = d[11:0];
            wr(1'b0, opas_pkg::REG_ALU_STAT, d);
            rd(opas_pkg::REG_ALU_STAT, {20'h0, st});
            st[6:5] = d[14:13];
            wr(1'b0, opas_pkg::REG_BYTE_IDX, d >> 13);
            rd(opas_pkg::REG_BYTE_IDX, {30'h0, st[6:5]});
            st[4:0] = d[20:16];
            wr(1'b1, 8'h00, d >> 16);
        end
        $display("status access test done");
        for (int i = 0; i < 40; i++) begin
            d = $urandom();
            op = 3'(1 + i % 5);
            r = {d[7], (i % 4 == 0) ? 32'h0 : $urandom()};
            st[9:8] = {r[31], r[31:0] == 32'h0};
            if (op != 3'h1)
                {st[10], st[7]} = {r[32] ^ d[3], r[32]};
            if (op == 3'h5)
                st[11] = d[5] | ~r[32];
            @(posedge ref_clk_in);
            alu_op_in <= op;
            alu_result_in <= r;
            alu_msb_carry_in <= d[3];
            div_flag_force_one_in <= d[5];
            settle();
        end
        $display("alu flag test done");
        for (int i = 0; i < 12; i++) begin
            d = $urandom();
            if (d[2])
                st[6:5] = d[4] ? {2{~d[3]}} : d[1:0];
            @(posedge ref_clk_in);
            ls_valid_in <= 1'b1;
            load_store_sets_byte_index_in <= d[2];
            ls_addr_low_in <= d[1:0];
            endianness_select_in <= d[3];
            byte_lane_source_select_in <= d[4];
            settle();
        end
        $display("load store test done");
        close_out();
    end
endmodule : operand_pointer_alu_status_bench
`default_nettype wire

//--- verilog/opas_pkg.sv
// opas_pkg: register numbers, field layout and encodings of the operand pointer
// and alu status register group; shared by the design and the bench
package opas_pkg;
    // special register numbers, as an 8-bit special-register index
    localparam logic [7:0] REG_PTR_A      = 8'h81;
    localparam logic [7:0] REG_PTR_B      = 8'h82;
    localparam logic [7:0] REG_MULDIV_EXT = 8'h83;
    localparam logic [7:0] REG_ALU_STAT   = 8'h84;
    localparam logic [7:0] REG_BYTE_IDX   = 8'h85;
    // indirect pointer field
    localparam int PTR_LSB = 2;
    localparam int PTR_MSB = 9;
    // alu status field positions
    localparam int DIV_BIT   = 11;
    localparam int OVF_BIT   = 10;
    localparam int NEG_BIT   = 9;
    localparam int ZERO_BIT  = 8;
    localparam int CARRY_BIT = 7;
    localparam int BIDX_MSB  = 6;
    localparam int BIDX_LSB  = 5;
    localparam int FSH_MSB   = 4;
    localparam int FSH_LSB   = 0;
    // alu result layout: 32 result bits plus the carry-out above them
    localparam int RES_LSB      = 0;
    localparam int RES_MSB      = 31;
    localparam int RES_COUT_BIT = 32;
    // byte index position inside its alias register
    localparam int ALIAS_BIDX_MSB = 1;
    localparam int ALIAS_BIDX_LSB = 0;
    // reset values
    localparam logic [7:0] PTR_RESET  = 8'h00;
    localparam logic [1:0] BIDX_RESET = 2'h0;
    localparam logic [4:0] FSH_RESET  = 5'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [4:0] OPND_GLOBAL0 = 5'h00;
    // alu operation classes reported by the execute stage
    typedef enum logic [2:0] {
        OPAS_OP_NONE   = 3'b000,
        OPAS_OP_LOGIC  = 3'b001,
        OPAS_OP_ARITH  = 3'b010,
        OPAS_OP_ARITHC = 3'b011,
        OPAS_OP_DIVSTP = 3'b100,
        OPAS_OP_DIVEND = 3'b101
    } opas_op_t;
endpackage : opas_pkg

//--- verilog/opas_regs.sv
// opas_regs: indirect operand pointers, alu status flags, byte index and funnel
// shift count of a processor core, with move-to/from-special-register access.
// assumes the pipeline supplies one alu outcome and one special write per cycle.
// assumes the configuration bits stay steady around the load/store they steer,
// that protection of the special registers is checked by the caller,
// and that the funnel-shift alias register lives outside and only strobes here.
`timescale 1ns/1ps
`default_nettype none
module opas_regs (
    input  wire logic        ref_clk_in,
    input  wire logic        reset_n_in,
    // operand decode
    input  wire logic [7:0]  first_source_select_in,
    input  wire logic [7:0]  second_source_select_in,
    output logic      [7:0]  first_reg_num_out,
    output logic      [7:0]  second_reg_num_out,
    // special register access
    input  wire logic        spr_wr_in,
    input  wire logic        spr_wr_fsh_alias_in,
    input  wire logic [7:0]  spr_addr_in,
    input  wire logic [31:0] spr_wdata_in,
    output logic      [31:0] spr_rdata_out,
    // alu outcome from execute
    input  wire logic [2:0]  alu_op_in,
    input  wire logic [32:0] alu_result_in,
    input  wire logic        alu_msb_carry_in,
    input  wire logic        div_flag_force_one_in,
    output logic             alu_carry_in_out,
    output logic             alu_subtract_out,
    // load/store byte index update
    input  wire logic        ls_valid_in,
    input  wire logic        load_store_sets_byte_index_in,
    input  wire logic [1:0]  ls_addr_low_in,
    input  wire logic        endianness_select_in,
    input  wire logic        byte_lane_source_select_in,
    // field views for insert/extract and funnel shifter
    output logic      [1:0]  byte_lane_out,
    output logic             half_word_upper_out,
    output logic      [4:0]  funnel_shift_amount_out,
    output logic      [31:0] alu_status_out
);
    logic [7:0] ptr_a_ff;
    logic [7:0] ptr_b_ff;
    logic [31:0] muldiv_ff;
    logic divide_step_flag_ff;
    logic ovf_ff;
    logic neg_ff;
    logic zero_ff;
    logic carry_ff;
    logic [1:0] byte_index_ff;
    logic [4:0] funnel_shift_amount_ff;
    logic [1:0] nxt_byte_index;
    logic [31:0] status_word;
    logic [31:0] nxt_rdata;
    logic wr_a;
    logic wr_b;
    logic wr_q;
    logic wr_stat;
    logic wr_bidx;
    opas_pkg::opas_op_t op;

    // per-flag update enables; kept apart so each flag has its own process
    logic upd_nz;   // any alu class loads negative and zero
    logic upd_vc;   // arithmetic and divide classes also load overflow and carry
    logic upd_df;   // only the division end step touches the divide flag
    logic res_zero; // all 32 result bits clear
    logic res_sign; // result msb, not the true sign on overflow
    logic res_cout; // 33rd alu bit, the carry-out

    // write decode: one strobe, five targets; unmapped numbers write nothing
    assign op      = opas_pkg::opas_op_t'(alu_op_in);
    assign wr_a    = spr_wr_in && (spr_addr_in == opas_pkg::REG_PTR_A);
    assign wr_b    = spr_wr_in && (spr_addr_in == opas_pkg::REG_PTR_B);
    assign wr_q    = spr_wr_in && (spr_addr_in == opas_pkg::REG_MULDIV_EXT);
    assign wr_stat = spr_wr_in && (spr_addr_in == opas_pkg::REG_ALU_STAT);
    assign wr_bidx = spr_wr_in && (spr_addr_in == opas_pkg::REG_BYTE_IDX);

    // a status write owns every flag in its cycle, so the alu outcome of that
    // cycle is dropped rather than merged; software reads back what it wrote
    assign upd_nz   = !wr_stat && (op == opas_pkg::OPAS_OP_LOGIC || upd_vc);
    assign upd_vc   = !wr_stat && (op == opas_pkg::OPAS_OP_ARITH
                                   || op == opas_pkg::OPAS_OP_ARITHC
                                   || op == opas_pkg::OPAS_OP_DIVSTP
                                   || op == opas_pkg::OPAS_OP_DIVEND);
    assign upd_df   = !wr_stat && (op == opas_pkg::OPAS_OP_DIVEND);
    assign res_cout = alu_result_in[opas_pkg::RES_COUT_BIT];
    assign res_sign = alu_result_in[opas_pkg::RES_MSB];
    assign res_zero = (alu_result_in[opas_pkg::RES_MSB:opas_pkg::RES_LSB] == opas_pkg::WORD_ZERO);

    // assembled status word; reserved bits stay zero
    always_comb begin
        status_word = opas_pkg::WORD_ZERO;
        status_word[opas_pkg::DIV_BIT]   = divide_step_flag_ff;
        status_word[opas_pkg::OVF_BIT]   = ovf_ff;
        status_word[opas_pkg::NEG_BIT]   = neg_ff;
        status_word[opas_pkg::ZERO_BIT]  = zero_ff;
        status_word[opas_pkg::CARRY_BIT] = carry_ff;
        status_word[opas_pkg::BIDX_MSB:opas_pkg::BIDX_LSB] = byte_index_ff;
        status_word[opas_pkg::FSH_MSB:opas_pkg::FSH_LSB]   = funnel_shift_amount_ff;
    end

    // indirect pointers: only bits 9:2 are stored, the rest is dropped
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ptr_a_ff <= opas_pkg::PTR_RESET;
            ptr_b_ff <= opas_pkg::PTR_RESET;
        end else begin
            if (wr_a) begin
                ptr_a_ff <= spr_wdata_in[opas_pkg::PTR_MSB:opas_pkg::PTR_LSB];
            end
            if (wr_b) begin
                ptr_b_ff <= spr_wdata_in[opas_pkg::PTR_MSB:opas_pkg::PTR_LSB];
            end
        end
    end

    // multiply/divide extension is kept as a plain word
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            muldiv_ff <= opas_pkg::WORD_ZERO;
        end else if (wr_q) begin
            muldiv_ff <= spr_wdata_in;
        end
    end

    // operand number select; registered so the outputs come from flops, which
    // costs decode one cycle of latency against the select inputs
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            first_reg_num_out  <= opas_pkg::PTR_RESET;
            second_reg_num_out <= opas_pkg::PTR_RESET;
        end else begin
            first_reg_num_out <= (first_source_select_in == {3'h0, opas_pkg::OPND_GLOBAL0})
                                 ? ptr_a_ff : first_source_select_in;
            second_reg_num_out <= (second_source_select_in == {3'h0, opas_pkg::OPND_GLOBAL0})
                                  ? ptr_b_ff : second_source_select_in;
        end
    end

    // divide flag: software load, or closed out at the end of a division;
    // a divide step only reads it, through the subtract view below
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            divide_step_flag_ff <= 1'b0;
        end else if (wr_stat) begin
            divide_step_flag_ff <= spr_wdata_in[opas_pkg::DIV_BIT];
        end else if (upd_df) begin
            divide_step_flag_ff <= div_flag_force_one_in | ~res_cout;
        end
    end

    // overflow: informational only, nothing in the core reads it back
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ovf_ff <= 1'b0;
        end else if (wr_stat) begin
            ovf_ff <= spr_wdata_in[opas_pkg::OVF_BIT];
        end else if (upd_vc) begin
            ovf_ff <= res_cout ^ alu_msb_carry_in;
        end
    end

    // negative: raw result msb, kept even when overflow makes it wrong
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            neg_ff <= 1'b0;
        end else if (wr_stat) begin
            neg_ff <= spr_wdata_in[opas_pkg::NEG_BIT];
        end else if (upd_nz) begin
            neg_ff <= res_sign;
        end
    end

    // zero: logic ops load it too, unlike overflow and carry
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            zero_ff <= 1'b0;
        end else if (wr_stat) begin
            zero_ff <= spr_wdata_in[opas_pkg::ZERO_BIT];
        end else if (upd_nz) begin
            zero_ff <= res_zero;
        end
    end

    // carry: logic ops leave it alone so a carry chain survives them
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            carry_ff <= 1'b0;
        end else if (wr_stat) begin
            carry_ff <= spr_wdata_in[opas_pkg::CARRY_BIT];
        end else if (upd_vc) begin
            carry_ff <= res_cout;
        end
    end

    // byte index sources; software write beats a load/store in the same cycle
    always_comb begin
        nxt_byte_index = byte_index_ff;
        if (wr_stat) begin
            nxt_byte_index = spr_wdata_in[opas_pkg::BIDX_MSB:opas_pkg::BIDX_LSB];
        end else if (wr_bidx) begin
            nxt_byte_index = spr_wdata_in[opas_pkg::ALIAS_BIDX_MSB:opas_pkg::ALIAS_BIDX_LSB];
        end else if (ls_valid_in && load_store_sets_byte_index_in) begin
            nxt_byte_index = byte_lane_source_select_in
                             ? {2{~endianness_select_in}} : ls_addr_low_in;
        end
    end

    // byte index register; every source is already merged in the mux above
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            byte_index_ff <= opas_pkg::BIDX_RESET;
        end else begin
            byte_index_ff <= nxt_byte_index;
        end
    end

    // funnel count; the alias register itself lives elsewhere and signals here
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            funnel_shift_amount_ff <= opas_pkg::FSH_RESET;
        end else if (wr_stat) begin
            funnel_shift_amount_ff <= spr_wdata_in[opas_pkg::FSH_MSB:opas_pkg::FSH_LSB];
        end else if (spr_wr_fsh_alias_in) begin
            funnel_shift_amount_ff <= spr_wdata_in[opas_pkg::FSH_MSB:opas_pkg::FSH_LSB];
        end
    end

    // read mux, registered: data appears the cycle after the address
    always_comb begin
        nxt_rdata = opas_pkg::WORD_ZERO;
        case (spr_addr_in)
            opas_pkg::REG_PTR_A:      nxt_rdata[opas_pkg::PTR_MSB:opas_pkg::PTR_LSB] = ptr_a_ff;
            opas_pkg::REG_PTR_B:      nxt_rdata[opas_pkg::PTR_MSB:opas_pkg::PTR_LSB] = ptr_b_ff;
            opas_pkg::REG_MULDIV_EXT: nxt_rdata = muldiv_ff;
            opas_pkg::REG_ALU_STAT:   nxt_rdata = status_word;
            opas_pkg::REG_BYTE_IDX: begin
                nxt_rdata[opas_pkg::ALIAS_BIDX_MSB:opas_pkg::ALIAS_BIDX_LSB] = byte_index_ff;
            end
            default:                  nxt_rdata = opas_pkg::WORD_ZERO;
        endcase
    end

    // registered read data and status word; a read in the cycle of a write to
    // the same register returns the old value
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            spr_rdata_out  <= opas_pkg::WORD_ZERO;
            alu_status_out <= opas_pkg::WORD_ZERO;
        end else begin
            spr_rdata_out  <= nxt_rdata;
            alu_status_out <= status_word;
        end
    end

    // registered views for the execute unit; they trail the flags by a cycle,
    // so the pipeline must hold off an op that depends on the previous one
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            alu_carry_in_out        <= 1'b0;
            alu_subtract_out        <= 1'b0;
            byte_lane_out           <= opas_pkg::BIDX_RESET;
            half_word_upper_out     <= 1'b0;
            funnel_shift_amount_out <= opas_pkg::FSH_RESET;
        end else begin
            alu_carry_in_out <= carry_ff;
            alu_subtract_out <= divide_step_flag_ff;
            // lane order flips with the endianness select
            byte_lane_out <= endianness_select_in ? ~byte_index_ff : byte_index_ff;
            half_word_upper_out <= endianness_select_in ? ~byte_index_ff[1]
                                                        : byte_index_ff[1];
            funnel_shift_amount_out <= funnel_shift_amount_ff;
        end
    end
endmodule : opas_regs
`default_nettype wire
